// File: wlb_pkg.sv
// package for the warning lamp blink code block
// assumes a 20 MHz system clock; all timing is counted in 100 ms ticks
package wlb_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // pedal times in ms
  localparam int unsigned ARM_REL_MS = 3000;
  localparam int unsigned PUMP_WIN_MS = 5000;
  localparam int unsigned PUMP_WAIT_MS = 7000;
  localparam int unsigned HOLD_MS = 10000;
  localparam int unsigned READY_SHOW_MS = 10000;
  localparam int unsigned ERASE_MS = 10000;
  localparam int unsigned DEB_MS = 100;
  // blink times in ms
  localparam int unsigned MSD_ON_MS = 600;
  localparam int unsigned MSD_OFF_MS = 600;
  localparam int unsigned LSD_ON_MS = 300;
  localparam int unsigned LSD_OFF_MS = 300;
  localparam int unsigned DIGIT_GAP_MS = 1000;
  localparam int unsigned CODE_GAP_MS = 1800;
  localparam int unsigned READY_BLINK_MS = 500;
  // tick counts; 300 ms rounds to 3 ticks exactly
  localparam logic [7:0] ARM_REL_T = 8'(ARM_REL_MS / TICK_MS);
  localparam logic [7:0] PUMP_WIN_T = 8'(PUMP_WIN_MS / TICK_MS);
  localparam logic [7:0] PUMP_WAIT_T = 8'(PUMP_WAIT_MS / TICK_MS);
  localparam logic [7:0] HOLD_T = 8'(HOLD_MS / TICK_MS);
  localparam logic [7:0] READY_SHOW_T = 8'(READY_SHOW_MS / TICK_MS);
  localparam logic [7:0] ERASE_T = 8'(ERASE_MS / TICK_MS);
  localparam logic [7:0] DEB_T = 8'(DEB_MS / TICK_MS);
  localparam logic [7:0] MSD_ON_T = 8'(MSD_ON_MS / TICK_MS);
  localparam logic [7:0] MSD_OFF_T = 8'(MSD_OFF_MS / TICK_MS);
  localparam logic [7:0] LSD_ON_T = 8'(LSD_ON_MS / TICK_MS);
  localparam logic [7:0] LSD_OFF_T = 8'(LSD_OFF_MS / TICK_MS);
  localparam logic [7:0] DIGIT_GAP_T = 8'(DIGIT_GAP_MS / TICK_MS);
  localparam logic [7:0] CODE_GAP_T = 8'(CODE_GAP_MS / TICK_MS);
  localparam logic [7:0] READY_BLINK_T = 8'(READY_BLINK_MS / TICK_MS);
  localparam logic [2:0] PUMP_COUNT = 3'h5;
  localparam logic [2:0] FS_TRIPS = 3'h5;
  localparam logic [4:0] ZERO_FLASHES = 5'h0A;
  localparam logic [4:0] HEX_A_FLASHES = 5'h0B;
  localparam logic [15:0] NO_FAULT_CODE = 16'h0000;

  // fault flags from the monitors, one set per driving cycle
  typedef struct packed {
    logic malfunction;    // confirmed two-trip malfunction
    logic one_trip;       // misfire or one-trip diagnosis
    logic fs_diag_failed; // throttle or controller diagnosis failed
    logic lamp_open;      // lamp circuit open
    logic pedal_sensor;   // pedal position sensor circuit faulty
    logic readiness_unset;
  } wlb_faults_t;

  // one stored code as seen by the display
  typedef struct packed {
    logic [15:0] code;
    logic confirmed;
  } wlb_code_t;

  typedef enum logic [3:0] {
    WLB_OFF = 4'h0,
    WLB_ARM = 4'h1,
    WLB_PUMP = 4'h2,
    WLB_WAIT = 4'h3,
    WLB_HOLD = 4'h4,
    WLB_READY = 4'h5,
    WLB_REL = 4'h6,
    WLB_IDLE = 4'h7
  } wlb_seq_t;

  typedef enum logic [2:0] {
    WLB_B_LOAD = 3'h0,
    WLB_B_ON = 3'h1,
    WLB_B_OFF = 3'h2,
    WLB_B_DGAP = 3'h3,
    WLB_B_CGAP = 3'h4
  } wlb_blink_t;
endpackage : wlb_pkg

// File: wlb_top.sv
// warning lamp control, pedal mode sequencer and blink code serialiser
// assumes synchronous inputs and a code store outside that answers an index
//
// Behaviour
// (RULE1) bulb check: ignition on, engine stopped
// (RULE2) running engine: lamp off unless malfunction
// (RULE3) running lamp only for two-trip malfunction; code also lights it while running for one_trip faults
// (RULE4) one-trip and misfire faults light immediately
// (RULE5) results mode shows confirmed and pending codes
// (RULE6) five failing trips enter failsafe
// (RULE7) failsafe cuts fuel above limit; code cuts fuel whenever failsafe is set, with no limit
// (RULE8) lamp may flash for unset readiness codes
// (RULE9) pedal sensor fault freezes mode changes
// (RULE10) ignition off returns to mode I
// (RULE11) release 3 s, five pumps in 5 s, wait 7 s
// (RULE12) hold 10 s, release enters results mode
// (RULE13) readiness blink shown further 10 s
// (RULE14) results mode hold over 10 s erases
// (RULE15) after erase show code 0000
// (RULE16) codes blink in a repeating list
// (RULE17) lamp off earlier means codes pending
// (RULE18) lamp lit, single code is confirmed
// (RULE19) four digits; zero ten, A eleven flashes
// (RULE20) top digit 0.6 s on, 0.6 s off
// (RULE21) lower digits 0.3 s on, 0.3 s off
// (RULE22) 1.0 s digit gap, 1.8 s code gap
// (RULE23) debounced pedal, common slow tick
`timescale 1ns/100ps
module wlb_top #(
  parameter int unsigned TICK_CYCLES = wlb_pkg::TICK_CYC,
  parameter int unsigned IDX_W = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // vehicle state
  input wire logic i_ign_on,
  input wire logic i_engine_run,
  input wire logic i_pedal_down,
  input wire logic i_pedal_up,
  input wire logic i_trip_end,
  input wire wlb_pkg::wlb_faults_t i_faults,
  // code store
  input wire wlb_pkg::wlb_code_t i_code,
  input wire logic [IDX_W-1:0] i_code_count,
  output logic [IDX_W-1:0] o_code_idx,
  output logic o_erase,
  // outputs
  output logic o_warning_lamp,
  output logic o_fuel_cut,
  output logic o_results_mode,
  output logic o_failsafe
);
  import wlb_pkg::*;

  function automatic logic [4:0] flashes(input logic [3:0] d);
    if (d == 4'h0) begin
      flashes = ZERO_FLASHES; // RULE19
    end else if (d == 4'hA) begin
      flashes = HEX_A_FLASHES; // RULE19
    end else begin
      flashes = {1'b0, d};
    end
  endfunction : flashes

  // slow tick; everything times from this one pulse
  logic [31:0] div_r;
  logic tick_r;
  always_ff @(posedge i_clk) begin
    if (i_reset || div_r == TICK_CYCLES - 1) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 32'h1;
    end
    tick_r <= !i_reset && div_r == TICK_CYCLES - 1; // RULE23
  end

  // pedal debounce on the tick; a bounce shorter than one tick is ignored
  logic dn_r, up_r, dn_prev_r, up_prev_r, dn_r_q, up_r_q;
  logic [7:0] dcnt_r, ucnt_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      // released is the idle level, so no false release follows reset
      dn_r <= 1'b0;
      up_r <= 1'b1;
      dn_prev_r <= 1'b0;
      up_prev_r <= 1'b1;
      dcnt_r <= '0;
      ucnt_r <= '0;
    end else if (tick_r) begin
      dn_prev_r <= i_pedal_down;
      up_prev_r <= i_pedal_up;
      dcnt_r <= (i_pedal_down != dn_prev_r) ? 8'h00 : dcnt_r + {7'h0, dcnt_r < DEB_T};
      ucnt_r <= (i_pedal_up != up_prev_r) ? 8'h00 : ucnt_r + {7'h0, ucnt_r < DEB_T};
      if (dcnt_r >= DEB_T) begin
        dn_r <= dn_prev_r; // RULE23
      end
      if (ucnt_r >= DEB_T) begin
        up_r <= up_prev_r; // RULE23
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dn_r_q <= 1'b0;
      up_r_q <= 1'b1;
    end else begin
      dn_r_q <= dn_r;
      up_r_q <= up_r;
    end
  end
  wire press = dn_r && !dn_r_q;
  wire release_ev = up_r && !up_r_q;

  // failsafe trip counter
  logic [2:0] fs_cnt_r;
  logic failsafe_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fs_cnt_r <= '0;
      failsafe_r <= 1'b0;
    end else begin
      if (i_trip_end) begin
        fs_cnt_r <= i_faults.fs_diag_failed ?
                    ((fs_cnt_r < FS_TRIPS) ? fs_cnt_r + 3'h1 : fs_cnt_r) : 3'h0;
      end
      if (fs_cnt_r >= FS_TRIPS) begin
        failsafe_r <= 1'b1; // RULE6
      end else if (i_faults.fs_diag_failed && !i_faults.lamp_open) begin
        failsafe_r <= 1'b1; // RULE7
      end
    end
  end

  // pedal sequencer
  wlb_seq_t seq_r;
  logic [7:0] tcnt_r;
  logic [2:0] pumps_r;
  logic results_r, erased_r, erase_r, ready_show_r;
  logic [7:0] ers_cnt_r;
  wire seq_go = !i_faults.pedal_sensor; // RULE9
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_ign_on) begin
      seq_r <= WLB_ARM; // RULE10
      tcnt_r <= '0;
      pumps_r <= '0;
      results_r <= 1'b0; // RULE10
      ready_show_r <= 1'b0;
    end else if (seq_go) begin
      if (tick_r) begin
        tcnt_r <= tcnt_r + {7'h0, tcnt_r != 8'hFF};
      end
      case (seq_r)
        WLB_ARM: begin
          if (i_engine_run || dn_r) begin
            seq_r <= WLB_IDLE;
          end else if (tcnt_r >= ARM_REL_T) begin
            seq_r <= WLB_PUMP; // RULE11
            tcnt_r <= '0;
          end
        end
        WLB_PUMP: begin
          if (release_ev) begin
            pumps_r <= pumps_r + 3'h1;
          end
          if (pumps_r == PUMP_COUNT && up_r) begin
            seq_r <= WLB_WAIT; // RULE11
            tcnt_r <= '0;
          end else if (tcnt_r >= PUMP_WIN_T) begin
            seq_r <= WLB_IDLE;
          end
        end
        WLB_WAIT: begin
          if (press) begin
            seq_r <= (tcnt_r >= PUMP_WAIT_T) ? WLB_HOLD : WLB_IDLE; // RULE11
            tcnt_r <= '0;
          end
        end
        WLB_HOLD: begin
          if (!dn_r) begin
            seq_r <= WLB_IDLE;
          end else if (tcnt_r >= HOLD_T) begin
            seq_r <= WLB_REL; // RULE12
            ready_show_r <= i_faults.readiness_unset; // RULE13
            tcnt_r <= '0;
          end
        end
        WLB_REL: begin
          if (tcnt_r >= READY_SHOW_T) begin
            ready_show_r <= 1'b0; // RULE13
          end
          if (release_ev) begin
            results_r <= !results_r; // RULE12
            ready_show_r <= 1'b0;
            seq_r <= WLB_IDLE;
          end
        end
        default: begin
          tcnt_r <= '0;
        end
      endcase
    end
  end

  // erase by long hold inside results mode
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_ign_on || !results_r) begin
      ers_cnt_r <= '0;
      erase_r <= 1'b0;
      erased_r <= 1'b0;
    end else begin
      erase_r <= 1'b0;
      if (!dn_r) begin
        ers_cnt_r <= '0;
      end else if (tick_r && ers_cnt_r <= ERASE_T) begin
        ers_cnt_r <= ers_cnt_r + 8'h1;
      end
      if (tick_r && ers_cnt_r == ERASE_T && !erased_r) begin
        erase_r <= 1'b1; // RULE14
        erased_r <= 1'b1;
      end
    end
  end

  // blink serialiser
  wlb_blink_t bst_r;
  logic [7:0] bcnt_r;
  logic [4:0] flash_left_r;
  logic [1:0] digit_r;
  logic [15:0] shown_r;
  logic [IDX_W-1:0] idx_r;
  logic blink_lamp_r;
  // slower top digit marks the start of each code
  wire [7:0] on_len = (digit_r == 2'd3) ? MSD_ON_T : LSD_ON_T; // RULE20 RULE21
  wire [7:0] off_len = (digit_r == 2'd3) ? MSD_OFF_T : LSD_OFF_T; // RULE20 RULE21
  always_ff @(posedge i_clk) begin
    if (i_reset || !results_r || dn_r) begin
      bst_r <= WLB_B_LOAD;
      bcnt_r <= '0;
      flash_left_r <= '0;
      digit_r <= 2'd3;
      shown_r <= NO_FAULT_CODE;
      idx_r <= '0;
      blink_lamp_r <= 1'b0;
    end else if (tick_r) begin
      bcnt_r <= bcnt_r + 8'h1;
      case (bst_r)
        WLB_B_LOAD: begin
          // an empty store or a fresh erase shows the no-fault code
          shown_r <= (erased_r || i_code_count == '0) ? NO_FAULT_CODE : i_code.code; // RULE15 RULE5
          flash_left_r <= flashes((erased_r || i_code_count == '0) ?
                                  NO_FAULT_CODE[15:12] : i_code.code[15:12]);
          digit_r <= 2'd3;
          bcnt_r <= '0;
          blink_lamp_r <= 1'b1;
          bst_r <= WLB_B_ON;
        end
        WLB_B_ON: begin
          if (bcnt_r + 8'h1 >= on_len) begin
            blink_lamp_r <= 1'b0;
            bcnt_r <= '0;
            flash_left_r <= flash_left_r - 5'h1;
            bst_r <= WLB_B_OFF;
          end
        end
        WLB_B_OFF: begin
          if (bcnt_r + 8'h1 >= off_len) begin
            bcnt_r <= '0;
            if (flash_left_r != 5'h0) begin
              blink_lamp_r <= 1'b1;
              bst_r <= WLB_B_ON;
            end else if (digit_r != 2'd0) begin
              bst_r <= WLB_B_DGAP;
            end else begin
              bst_r <= WLB_B_CGAP;
            end
          end
        end
        WLB_B_DGAP: begin
          if (bcnt_r + 8'h1 >= DIGIT_GAP_T) begin
            bcnt_r <= '0;
            digit_r <= digit_r - 2'd1;
            flash_left_r <= flashes(shown_r[4*(digit_r-2'd1) +: 4]); // RULE19
            blink_lamp_r <= 1'b1;
            bst_r <= WLB_B_ON; // RULE22
          end
        end
        default: begin
          if (bcnt_r + 8'h1 >= CODE_GAP_T) begin
            // wrap the list so it repeats
            idx_r <= (idx_r + 1'b1 >= i_code_count) ? '0 : idx_r + 1'b1; // RULE16
            bst_r <= WLB_B_LOAD; // RULE22
          end
        end
      endcase
    end
  end

  // readiness flasher and lamp mux
  logic ready_ph_r;
  logic [7:0] rcnt_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ready_ph_r <= 1'b0;
      rcnt_r <= '0;
    end else if (tick_r) begin
      rcnt_r <= (rcnt_r + 8'h1 >= READY_BLINK_T) ? 8'h00 : rcnt_r + 8'h1;
      if (rcnt_r + 8'h1 >= READY_BLINK_T) begin
        ready_ph_r <= !ready_ph_r;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || !i_ign_on) begin
      o_warning_lamp <= 1'b0;
      o_fuel_cut <= 1'b0;
      o_results_mode <= 1'b0;
      o_failsafe <= 1'b0;
      o_erase <= 1'b0;
      o_code_idx <= '0;
    end else begin
      o_results_mode <= results_r; // RULE5 RULE17 RULE18
      o_failsafe <= failsafe_r; // RULE6
      o_fuel_cut <= failsafe_r; // RULE7
      o_erase <= erase_r; // RULE14
      o_code_idx <= idx_r;
      if (ready_show_r) begin
        o_warning_lamp <= ready_ph_r; // RULE13
      end else if (results_r) begin
        o_warning_lamp <= blink_lamp_r; // RULE16
      end else if (!i_engine_run) begin
        o_warning_lamp <= 1'b1; // RULE1
      end else if (i_faults.malfunction || i_faults.one_trip) begin
        o_warning_lamp <= 1'b1; // RULE3 RULE4
      end else if (i_faults.readiness_unset) begin
        o_warning_lamp <= ready_ph_r; // RULE8
      end else begin
        o_warning_lamp <= 1'b0; // RULE2
      end
    end
  end
endmodule : wlb_top

// File: wlb_top_assertions.sv
// checker for the warning lamp block, bound into wlb_top
// assumes the pedal stays released while codes are being shown
`timescale 1ns/100ps
module wlb_chk #(
  parameter int unsigned TICK_CYCLES = wlb_pkg::TICK_CYC,
  parameter int unsigned IDX_W = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // vehicle state
  input wire logic i_ign_on,
  input wire logic i_engine_run,
  input wire logic i_pedal_down,
  input wire logic i_pedal_up,
  input wire logic i_trip_end,
  input wire wlb_pkg::wlb_faults_t i_faults,
  // code store
  input wire wlb_pkg::wlb_code_t i_code,
  input wire logic [IDX_W-1:0] i_code_count,
  input wire logic [IDX_W-1:0] o_code_idx,
  input wire logic o_erase,
  // outputs
  input wire logic o_warning_lamp,
  input wire logic o_fuel_cut,
  input wire logic o_results_mode,
  input wire logic o_failsafe
);
  import wlb_pkg::*;
  // lit run length; saturates when the run began outside results mode
  logic [15:0] on_len_r;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_warning_lamp) begin
      on_len_r <= 16'h0000;
    end else if (!o_results_mode) begin
      on_len_r <= 16'hFFFF;
    end else if (on_len_r != 16'hFFFF) begin
      on_len_r <= on_len_r + 16'h0001;
    end
  end
  a_ign_off_clear: assert property (!i_ign_on |=> !o_warning_lamp && !o_results_mode)
    else $error("lamp or mode on with key off");
  a_run_lamp_off: assert property (i_ign_on && i_engine_run && !i_faults.malfunction
    && !i_faults.one_trip && !i_faults.readiness_unset && !o_failsafe && !o_results_mode
    |=> !o_warning_lamp) else $error("lamp on while running clean");
  a_run_lamp_on: assert property (i_ign_on && i_engine_run && i_faults.malfunction
    && !i_faults.one_trip && !o_failsafe && !o_results_mode |=> o_warning_lamp)
    else $error("malfunction not lit");
  a_fs_direct: assert property (i_ign_on && i_faults.fs_diag_failed
    && !i_faults.lamp_open |-> ##[1:2] o_failsafe) else $error("failsafe missing");
  a_fuel_cut_fs: assert property (o_fuel_cut |-> o_failsafe)
    else $error("fuel cut without failsafe");
  a_mode_frozen: assert property ((i_ign_on && i_faults.pedal_sensor)[*3]
    |=> $stable(o_results_mode)) else $error("mode moved with sensor fault");
  a_erase_pulse: assert property (o_erase |-> o_results_mode ##1 !o_erase)
    else $error("erase pulse wrong");
  a_flash_width: assert property ($fell(o_warning_lamp) && o_results_mode
    && !i_pedal_down && on_len_r != 16'hFFFF |-> on_len_r == 16'(6 * TICK_CYCLES)
    || on_len_r == 16'(3 * TICK_CYCLES)) else $error("flash width wrong");
endmodule : wlb_chk

bind wlb_top wlb_chk #(.TICK_CYCLES(TICK_CYCLES), .IDX_W(IDX_W)) i_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_ign_on(i_ign_on), .i_engine_run(i_engine_run),
  .i_pedal_down(i_pedal_down), .i_pedal_up(i_pedal_up), .i_trip_end(i_trip_end),
  .i_faults(i_faults), .i_code(i_code), .i_code_count(i_code_count),
  .o_code_idx(o_code_idx), .o_erase(o_erase), .o_warning_lamp(o_warning_lamp),
  .o_fuel_cut(o_fuel_cut), .o_results_mode(o_results_mode), .o_failsafe(o_failsafe));

// File: wlb_driver.sv
// driver model: ignition key and accelerator pedal switches
// assumes its tasks are entered just after a rising clock edge
`timescale 1ns/100ps
module wlb_driver #(
  parameter int unsigned TK = 20
) (
  // clock
  input wire logic i_clk,
  // key and pedal switches
  output logic o_ign_on,
  output logic o_pedal_down,
  output logic o_pedal_up
);
  import wlb_pkg::*;
  initial begin
    o_ign_on = 1'b0;
    o_pedal_down = 1'b0;
    o_pedal_up = 1'b1;
  end
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge i_clk);
    #5;
  endtask : ticks
  task automatic key(input logic on);
    o_ign_on = on;
  endtask : key
  // mid travel neither switch is closed
  task automatic press(input logic dn);
    o_pedal_down = 1'b0;
    o_pedal_up = 1'b0;
    ticks(1);
    o_pedal_down = dn;
    o_pedal_up = !dn;
  endtask : press
  task automatic enter_seq();
    key(1'b0);
    ticks(2);
    key(1'b1);
    ticks(35);
    repeat (5) begin
      press(1'b1);
      ticks(3);
      press(1'b0);
      ticks(3);
    end
    ticks(75);
    press(1'b1);
    ticks(120);
    press(1'b0);
  endtask : enter_seq
endmodule : wlb_driver

// File: wlb_top_tb_top.sv
// testbench for wlb_top with a driver model and a two-entry code store
// assumes a short tick of 20 clocks so the pedal sequences stay brief
`timescale 1ns/100ps
module wlb_top_tb_top;
  import wlb_pkg::*;
  localparam int unsigned TK = 20;
  logic clk;
  logic rst;
  logic eng;
  logic trip;
  wlb_faults_t flt;
  logic [3:0] cnt;
  logic [3:0] idx;
  logic ers, lamp, fcut, rmode, fsafe, ign, pdn, pup;
  wlb_code_t code;
  logic [15:0] cur = 16'h0000;
  logic [15:0] last_code = 16'h0000;
  int off_len = 0, flashes = 0, ndig = 0, ncodes = 0;
  int bad_count = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  assign code = {(idx == 4'h0) ? 16'h0A12 : 16'h3A07, idx == 4'h0};
  always @(posedge clk) if (ers) cnt <= 4'h0;
  wlb_driver #(.TK(TK)) i_drv (.i_clk(clk), .o_ign_on(ign), .o_pedal_down(pdn),
    .o_pedal_up(pup));
  wlb_top #(.TICK_CYCLES(TK), .IDX_W(4)) i_dut (.i_clk(clk), .i_reset(rst),
    .i_ign_on(ign), .i_engine_run(eng), .i_pedal_down(pdn), .i_pedal_up(pup),
    .i_trip_end(trip), .i_faults(flt), .i_code(code), .i_code_count(cnt),
    .o_code_idx(idx), .o_erase(ers), .o_warning_lamp(lamp), .o_fuel_cut(fcut),
    .o_results_mode(rmode), .o_failsafe(fsafe));
  function automatic logic [3:0] fl2dig(input int n);
    return (n == 10) ? 4'h0 : (n == 11) ? 4'hA : 4'(n);
  endfunction : fl2dig
  // flash decoder: short offs split flashes, longer offs digits and codes
  always @(posedge clk) begin
    if (!rmode) begin
      off_len = 0;
      flashes = 0;
      ndig = 0;
    end else if (!lamp) begin
      off_len++;
    end else if (off_len > 0) begin
      if (off_len > 8 * TK && flashes > 0) begin
        cur = {cur[11:0], fl2dig(flashes)};
        ndig++;
        flashes = 0;
        if (off_len > 18 * TK) begin
          if (ndig == 4) begin
            last_code = cur;
            ncodes++;
          end
          ndig = 0;
        end
      end
      flashes++;
      off_len = 0;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : cyc
  task automatic chk1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk1
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask : chk16
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic do_reset();
    rst = 1'b1;
    cyc(4);
    chk1(lamp | rmode | fsafe | fcut | ers, 1'b0, "outputs in reset");
    rst = 1'b0;
  endtask : do_reset
  // waits for one whole decoded code; the wait gives up after 20000 clocks
  task automatic next_code(output logic [15:0] c);
    int n0;
    n0 = ncodes;
    for (int i = 0; i < 20000 && ncodes == n0; i++) cyc(1);
    chk1(ncodes != n0, 1'b1, "no code shown");
    c = last_code;
  endtask : next_code
  task automatic t_lamp();
    i_drv.key(1'b1);
    cyc(2);
    chk1(lamp, 1'b1, "bulb check");
    eng = 1'b1;
    cyc(2);
    chk1(lamp, 1'b0, "lamp while running");
    flt.malfunction = 1'b1;
    cyc(2);
    chk1(lamp, 1'b1, "malfunction");
    flt = '0;
    cyc(2);
    chk1(lamp, 1'b0, "no malfunction");
    flt.readiness_unset = 1'b1;
    for (int i = 0; i < 12 * TK && lamp !== 1'b1; i++) cyc(1);
    chk1(lamp, 1'b1, "readiness flash on");
    for (int i = 0; i < 12 * TK && lamp !== 1'b0; i++) cyc(1);
    chk1(lamp, 1'b0, "readiness flash off");
    flt = '0;
    cyc(2);
    flt.one_trip = 1'b1;
    for (int i = 0; i < 400 && lamp !== 1'b1; i++) cyc(1);
    chk1(lamp, 1'b1, "one trip fault");
    i_drv.key(1'b0);
    cyc(2);
    chk1(lamp | rmode, 1'b0, "key off");
    flt = '0;
    eng = 1'b0;
  endtask : t_lamp
  task automatic t_failsafe();
    i_drv.key(1'b1);
    eng = 1'b1;
    flt.fs_diag_failed = 1'b1;
    flt.lamp_open = 1'b1;
    repeat (4) begin
      trip = 1'b1;
      cyc(1);
      trip = 1'b0;
      cyc(3);
    end
    chk1(fsafe, 1'b0, "failsafe early");
    trip = 1'b1;
    cyc(1);
    trip = 1'b0;
    cyc(2);
    chk1(fsafe, 1'b1, "failsafe after five trips");
    chk1(fcut, 1'b1, "fuel cut");
    do_reset();
    flt.lamp_open = 1'b0;
    cyc(3);
    chk1(fsafe, 1'b1, "failsafe direct");
    flt = '0;
    eng = 1'b0;
    do_reset();
  endtask : t_failsafe
  task automatic t_frozen();
    flt.pedal_sensor = 1'b1;
    i_drv.enter_seq();
    cyc(5 * TK);
    chk1(rmode, 1'b0, "mode changed with sensor fault");
    flt = '0;
  endtask : t_frozen
  task automatic t_results();
    logic [15:0] c0, c1;
    int n;
    i_drv.enter_seq();
    cyc(5 * TK);
    chk1(rmode, 1'b1, "results mode not entered");
    next_code(c0);
    next_code(c0);
    next_code(c1);
    chk16(c0 == 16'h0A12 ? c1 : c0, 16'h3A07, "code list");
    chk16(c0 == 16'h0A12 ? c0 : c1, 16'h0A12, "code list");
    i_drv.press(1'b1);
    for (n = 0; n < 130 * TK && ers !== 1'b1; n++) cyc(1);
    chk1(ers && n >= 100 * TK, 1'b1, "erase after hold");
    i_drv.press(1'b0);
    next_code(c0);
    next_code(c0);
    chk16(c0, NO_FAULT_CODE, "code after erase");
    i_drv.key(1'b0);
    cyc(2);
    chk1(rmode, 1'b0, "mode kept after key off");
  endtask : t_results
  initial begin
    #4000000;
    bad_count++;
    end_sim();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    eng = 1'b0;
    trip = 1'b0;
    flt = '0;
    cnt = 4'h2;
    do_reset();
    t_lamp();
    t_failsafe();
    t_frozen();
    t_results();
    end_sim();
  end
endmodule : wlb_top_tb_top
